// >>> icch_pkg.sv
// constants and carrier types of the io configuration command handler
// assumes one 250 MHz clock, commands arriving as a byte stream
// Function
// - config packet header f8 03 0b, echoed back
// - update select mask picks which items write
// - pin assignment config byte fields decoded
// - timers then counters on consecutive lines
// - revision 1.30 accepts pin offset 4-8 only
// - enabled timers reset to mode 10
// - first counter off for tick sources 3-6
// - uart pin bit applied only with mask bit5
// - second dac bit on old revisions only
// - old revisions use regulator reference when enabled
// - flexible mask bit one means analog input
// - extended mask bit one means analog input
// - timer clock command header 02 0a
// - tick config bit7 stores select and divide
// - tick divided by value for sources 3-6, zero means 256
package icch_pkg;
  localparam int MAX_LEN = 12;
  localparam logic [7:0] HDR_SYNC = 8'hF8;
  localparam logic [7:0] CIO_WORDS = 8'h03;
  localparam logic [7:0] CIO_CMD = 8'h0B;
  localparam logic [7:0] TCK_WORDS = 8'h02;
  localparam logic [7:0] TCK_CMD = 8'h0A;
  localparam logic [3:0] CIO_LEN = 4'hC;
  localparam logic [3:0] TCK_LEN = 4'hA;
  // byte positions in command and response
  localparam int POS_SUM8 = 0;
  localparam int POS_SYNC = 1;
  localparam int POS_WORDS = 2;
  localparam int POS_CMD = 3;
  localparam int POS_S16L = 4;
  localparam int POS_S16H = 5;
  localparam int POS_MASK = 6;
  localparam int POS_ERR = 6;
  localparam int POS_RSV = 7;
  localparam int POS_PIN = 8;
  localparam int POS_DAC = 9;
  localparam int POS_FIO = 10;
  localparam int POS_EIO = 11;
  localparam int POS_TCFG = 8;
  localparam int POS_TDIV = 9;
  // update select mask bits
  localparam int WM_PIN = 0;
  localparam int WM_DAC = 1;
  localparam int WM_FIO = 2;
  localparam int WM_EIO = 3;
  localparam int WM_UART = 5;
  // pin assignment config fields
  localparam int PC_NTMR_LSB = 0;
  localparam int PC_C0 = 2;
  localparam int PC_C1 = 3;
  localparam int PC_OFF_LSB = 4;
  // second dac control fields
  localparam int DC_EN = 0;
  localparam int DC_UART = 2;
  // tick source config fields
  localparam int TCFG_WR = 7;
  localparam logic [7:0] HW_REV_130 = 8'h82;
  localparam logic [3:0] PIN_OFF_MIN = 4'h4;
  localparam logic [3:0] PIN_OFF_MAX = 4'h8;
  localparam logic [2:0] SEL_DIV_MIN = 3'h3;
  localparam logic [2:0] SEL_DIV_MAX = 3'h6;
  localparam logic [3:0] TIMER_MODE_INIT = 4'hA;
  // reset values
  localparam logic [7:0] RST_PIN_CFG = 8'h40;
  localparam logic [7:0] RST_DAC = 8'h00;
  localparam logic [7:0] RST_FIO = 8'h0F;
  localparam logic [7:0] RST_EIO = 8'h00;
  localparam logic [2:0] RST_TSEL = 3'h2;
  localparam logic [7:0] RST_TDIV = 8'h00;
  // error results
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_SUM8 = 8'h01;
  localparam logic [7:0] ERR_SUM16 = 8'h02;
  localparam logic [7:0] ERR_HEADER = 8'h03;
  localparam logic [7:0] ERR_PIN_OFFSET = 8'h04;

  typedef logic [MAX_LEN-1:0][7:0] icch_pkt_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } icch_stream_type;

  typedef struct packed {
    logic [7:0] pin_cfg;
    logic [7:0] dac_ctl;
    logic [7:0] fio;
    logic [7:0] eio;
    logic [2:0] tick_sel;
    logic [7:0] tick_div;
  } icch_cfg_type;

  typedef struct packed {
    logic [4:0] t0;
    logic [4:0] t1;
    logic [4:0] c0;
    logic [4:0] c1;
  } icch_lines_type;
endpackage : icch_pkg

// >>> icch_sum.sv
// header_sum and payload_sum of one packet
// assumes bytes beyond i_len are ignored; i_fill uses own payload_sum
`timescale 1ns/100ps
module icch_sum (
  input icch_pkg::icch_pkt_type i_pkt,
  input wire logic [3:0] i_len,
  input wire logic i_fill,
  output logic [7:0] o_sum8,
  output logic [15:0] o_sum16
);
  import icch_pkg::*;
  logic [10:0] s8;
  logic [8:0] f1;
  logic [8:0] f2;
  logic [7:0] b4;
  logic [7:0] b5;

  always_comb begin
    o_sum16 = 16'h0000;
    for (int i = POS_MASK; i < MAX_LEN; i++) begin
      if (i < int'(i_len)) begin
        o_sum16 = o_sum16 + {8'h00, i_pkt[i]};
      end
    end
  end

  assign b4 = i_fill ? o_sum16[7:0] : i_pkt[POS_S16L];
  assign b5 = i_fill ? o_sum16[15:8] : i_pkt[POS_S16H];
  assign s8 = {3'b000, i_pkt[POS_SYNC]} + {3'b000, i_pkt[POS_WORDS]}
    + {3'b000, i_pkt[POS_CMD]} + {3'b000, b4} + {3'b000, b5};
  // fold carries back in twice
  assign f1 = {1'b0, s8[7:0]} + {6'h00, s8[10:8]};
  assign f2 = {1'b0, f1[7:0]} + {8'h00, f1[8]};
  assign o_sum8 = f2[7:0];
endmodule : icch_sum

// >>> icch_tick_div.sv
// timer tick divider; base tick is a one-cycle enable from the clock tree
// assumes i_sel and i_div are stable register values
`timescale 1ns/100ps
module icch_tick_div (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_base_tick,
  input wire logic [2:0] i_sel,
  input wire logic [7:0] i_div,
  output logic o_tick
);
  import icch_pkg::*;
  logic [7:0] cnt_q;
  logic [7:0] term;
  logic div_on;

  // zero wraps to 255, giving 256 base ticks
  assign term = i_div - 8'h01;
  assign div_on = (i_sel >= SEL_DIV_MIN) && (i_sel <= SEL_DIV_MAX);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= 8'h00;
      o_tick <= 1'b0;
    end else if (!div_on) begin
      cnt_q <= 8'h00;
      o_tick <= i_base_tick;
    end else if (i_base_tick) begin
      cnt_q <= (cnt_q == term) ? 8'h00 : cnt_q + 8'h01;
      o_tick <= (cnt_q == term);
    end else begin
      o_tick <= 1'b0;
    end
  end

  property p_tick_pass;
    @(posedge i_clk) disable iff (i_sys_rst)
      !div_on && i_base_tick && $stable(i_sel) |=> o_tick;
  endproperty
  a_tick_pass: assert property (p_tick_pass)
    else $error("undivided tick not passed through");

  property p_tick_256;
    @(posedge i_clk) disable iff (i_sys_rst)
      div_on && i_div == 8'h00 && i_base_tick && cnt_q == 8'h00
      |=> !o_tick;
  endproperty
  a_tick_256: assert property (p_tick_256)
    else $error("zero divide value did not mean 256");
endmodule : icch_tick_div

// >>> icch_handler.sv
// io configuration and timer clock command handler
// assumes command bytes arrive on the same clock from the usb link logic
`timescale 1ns/100ps
module icch_handler #(
  parameter logic [7:0] P_HW_REV = 8'h82
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input icch_pkg::icch_stream_type i_rx,
  output logic o_rx_ready,
  output icch_pkg::icch_stream_type o_tx,
  input wire logic i_tx_ready,
  input wire logic i_base_tick,
  output icch_pkg::icch_cfg_type o_cfg,
  output icch_pkg::icch_lines_type o_lines,
  output logic [1:0] o_timer_count,
  output logic o_first_counter_en,
  output logic o_second_counter_en,
  output logic [1:0] o_timer_init,
  output logic o_dac2_en,
  output logic o_ain_ref_vreg,
  output logic o_uart_pins,
  output logic [7:0] o_fio_analog,
  output logic [7:0] o_eio_analog,
  output logic o_tick
);
  import icch_pkg::*;
  localparam logic NEW_HW = (P_HW_REV >= HW_REV_130);

  typedef enum logic [1:0] {S_RX, S_CHECK, S_TX} icch_state_type;
  icch_state_type state_q;
  icch_pkt_type rx_q;
  icch_pkt_type tx_pkt;
  icch_pkt_type tx_out;
  logic [3:0] rx_cnt_q;
  logic [3:0] tx_idx_q;
  logic [3:0] tx_len;
  logic [7:0] err_q;
  logic [7:0] err_d;
  logic tck_q;
  icch_cfg_type cfg_q;
  icch_cfg_type cfg_d;
  logic [7:0] rx_sum8;
  logic [15:0] rx_sum16;
  logic [7:0] tx_sum8;
  logic [15:0] tx_sum16;
  logic is_cio;
  logic is_tck;
  logic ok;
  logic [7:0] wm;
  logic [3:0] off_new;
  logic off_bad;
  logic [1:0] ntmr_d;
  logic c0_avail;
  logic c0_on;
  logic [4:0] base;
  logic [4:0] c0_line;
  logic [7:0] dac_rpt;
  logic [7:0] tcfg_rpt;

  // receive side packet checks
  icch_sum u_rx_sum (
    .i_pkt(rx_q),
    .i_len(rx_cnt_q),
    .i_fill(1'b0),
    .o_sum8(rx_sum8),
    .o_sum16(rx_sum16)
  );

  assign is_cio = rx_q[POS_SYNC] == HDR_SYNC && rx_q[POS_WORDS] == CIO_WORDS
    && rx_q[POS_CMD] == CIO_CMD && rx_cnt_q == CIO_LEN;
  assign is_tck = rx_q[POS_SYNC] == HDR_SYNC && rx_q[POS_WORDS] == TCK_WORDS
    && rx_q[POS_CMD] == TCK_CMD && rx_cnt_q == TCK_LEN;
  // reserved mask bit 4 is simply never looked at
  assign wm = is_cio ? rx_q[POS_MASK] : 8'h00;
  assign off_new = rx_q[POS_PIN][PC_OFF_LSB +: 4];
  assign off_bad = NEW_HW && wm[WM_PIN]
    && (off_new < PIN_OFF_MIN || off_new > PIN_OFF_MAX);

  always_comb begin
    if (!(is_cio || is_tck)) begin
      err_d = ERR_HEADER;
    end else if (rx_sum8 != rx_q[POS_SUM8]) begin
      err_d = ERR_SUM8;
    end else if (rx_sum16 != {rx_q[POS_S16H], rx_q[POS_S16L]}) begin
      err_d = ERR_SUM16;
    end else if (off_bad) begin
      err_d = ERR_PIN_OFFSET;
    end else begin
      err_d = ERR_NONE;
    end
  end
  assign ok = (err_d == ERR_NONE);

  // masked writes; unselected items are only reported
  always_comb begin
    cfg_d = cfg_q;
    if (ok && is_cio) begin
      if (wm[WM_PIN]) begin
        cfg_d.pin_cfg = rx_q[POS_PIN];
      end
      if (wm[WM_DAC] && !NEW_HW) begin
        cfg_d.dac_ctl[DC_EN] = rx_q[POS_DAC][DC_EN];
      end
      if (wm[WM_UART] && NEW_HW) begin
        cfg_d.dac_ctl[DC_UART] = rx_q[POS_DAC][DC_UART];
      end
      if (wm[WM_FIO]) begin
        cfg_d.fio = rx_q[POS_FIO];
      end
      if (wm[WM_EIO]) begin
        cfg_d.eio = rx_q[POS_EIO];
      end
    end
    if (ok && is_tck && rx_q[POS_TCFG][TCFG_WR]) begin
      cfg_d.tick_sel = rx_q[POS_TCFG][2:0];
      cfg_d.tick_div = rx_q[POS_TDIV];
    end
  end
  assign ntmr_d = cfg_d.pin_cfg[PC_NTMR_LSB +: 2];

  // line assignment from the stored configuration
  assign c0_avail = !(cfg_q.tick_sel >= SEL_DIV_MIN
    && cfg_q.tick_sel <= SEL_DIV_MAX);
  assign c0_on = cfg_q.pin_cfg[PC_C0] && c0_avail;
  assign base = {1'b0, cfg_q.pin_cfg[PC_OFF_LSB +: 4]};
  assign c0_line = base + {3'b000, cfg_q.pin_cfg[PC_NTMR_LSB +: 2]};
  assign dac_rpt = {5'b00000, cfg_q.dac_ctl[DC_UART], 1'b0,
    NEW_HW | cfg_q.dac_ctl[DC_EN]};
  assign tcfg_rpt = {5'b00000, cfg_q.tick_sel};

  // response built from the configuration after the writes
  always_comb begin
    tx_pkt = '0;
    tx_pkt[POS_SYNC] = HDR_SYNC;
    tx_pkt[POS_WORDS] = tck_q ? TCK_WORDS : CIO_WORDS;
    tx_pkt[POS_CMD] = tck_q ? TCK_CMD : CIO_CMD;
    tx_pkt[POS_ERR] = err_q;
    if (tck_q) begin
      tx_pkt[POS_TCFG] = tcfg_rpt;
      tx_pkt[POS_TDIV] = cfg_q.tick_div;
    end else begin
      tx_pkt[POS_PIN] = cfg_q.pin_cfg;
      tx_pkt[POS_DAC] = dac_rpt;
      tx_pkt[POS_FIO] = cfg_q.fio;
      tx_pkt[POS_EIO] = cfg_q.eio;
    end
  end
  assign tx_len = tck_q ? TCK_LEN : CIO_LEN;

  icch_sum u_tx_sum (
    .i_pkt(tx_pkt),
    .i_len(tx_len),
    .i_fill(1'b1),
    .o_sum8(tx_sum8),
    .o_sum16(tx_sum16)
  );
  assign tx_out = {tx_pkt[MAX_LEN-1:POS_MASK], tx_sum16,
    tx_pkt[POS_CMD:POS_SYNC], tx_sum8};

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= S_RX;
      rx_q <= '0;
      rx_cnt_q <= 4'h0;
      tx_idx_q <= 4'h0;
      err_q <= ERR_NONE;
      tck_q <= 1'b0;
      o_rx_ready <= 1'b1;
      o_tx <= '0;
      o_timer_init <= 2'b00;
    end else begin
      o_timer_init <= 2'b00;
      unique case (state_q)
        S_RX: begin
          if (i_rx.valid) begin
            if (rx_cnt_q < CIO_LEN) begin
              rx_q[rx_cnt_q] <= i_rx.data;
            end
            // saturates one past the longest packet
            if (rx_cnt_q <= CIO_LEN) begin
              rx_cnt_q <= rx_cnt_q + 4'h1;
            end
            if (i_rx.last) begin
              o_rx_ready <= 1'b0;
              state_q <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          err_q <= err_d;
          tck_q <= is_tck;
          if (ok && is_cio) begin
            o_timer_init <= {ntmr_d >= 2'h2, ntmr_d != 2'h0};
          end
          tx_idx_q <= 4'h0;
          state_q <= S_TX;
        end
        S_TX: begin
          if (!o_tx.valid || i_tx_ready) begin
            if (tx_idx_q < tx_len) begin
              o_tx.valid <= 1'b1;
              o_tx.data <= tx_out[tx_idx_q];
              o_tx.last <= (tx_idx_q == tx_len - 4'h1);
              tx_idx_q <= tx_idx_q + 4'h1;
            end else begin
              o_tx <= '0;
              rx_cnt_q <= 4'h0;
              o_rx_ready <= 1'b1;
              state_q <= S_RX;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg_q <= '{RST_PIN_CFG, RST_DAC, RST_FIO, RST_EIO, RST_TSEL, RST_TDIV};
    end else if (state_q == S_CHECK) begin
      cfg_q <= cfg_d;
    end
  end

  // registered views of the configuration
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cfg <= '0;
      o_lines <= '0;
      o_timer_count <= 2'b00;
      o_first_counter_en <= 1'b0;
      o_second_counter_en <= 1'b0;
      o_dac2_en <= NEW_HW;
      o_ain_ref_vreg <= 1'b0;
      o_uart_pins <= 1'b0;
      o_fio_analog <= 8'h00;
      o_eio_analog <= 8'h00;
    end else begin
      o_cfg <= cfg_q;
      o_lines.t0 <= base;
      o_lines.t1 <= base + 5'h01;
      o_lines.c0 <= c0_line;
      o_lines.c1 <= c0_line + {4'h0, c0_on};
      o_timer_count <= cfg_q.pin_cfg[PC_NTMR_LSB +: 2];
      o_first_counter_en <= c0_on;
      o_second_counter_en <= cfg_q.pin_cfg[PC_C1];
      o_dac2_en <= NEW_HW | cfg_q.dac_ctl[DC_EN];
      o_ain_ref_vreg <= !NEW_HW && cfg_q.dac_ctl[DC_EN];
      o_uart_pins <= NEW_HW && cfg_q.dac_ctl[DC_UART];
      o_fio_analog <= cfg_q.fio;
      o_eio_analog <= cfg_q.eio;
    end
  end

  icch_tick_div u_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_base_tick(i_base_tick),
    .i_sel(cfg_q.tick_sel),
    .i_div(cfg_q.tick_div),
    .o_tick(o_tick)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_reject;
    state_q == S_CHECK && !ok |=> cfg_q == $past(cfg_q) && err_q != ERR_NONE;
  endproperty
  a_reject: assert property (p_reject)
    else $error("rejected command changed configuration");

  property p_pin_write;
    state_q == S_CHECK && ok && wm[WM_PIN] |=> cfg_q.pin_cfg == $past(rx_q[8]);
  endproperty
  a_pin_write: assert property (p_pin_write)
    else $error("selected pin config not stored");

  property p_unselected;
    state_q == S_CHECK && !wm[WM_FIO] |=> $stable(cfg_q.fio);
  endproperty
  a_unselected: assert property (p_unselected)
    else $error("unselected flexible mask changed");

  property p_offset;
    state_q == S_CHECK && (is_cio || is_tck) && rx_sum8 == rx_q[0]
      && off_bad && rx_sum16 == {rx_q[5], rx_q[4]}
      |=> err_q == ERR_PIN_OFFSET;
  endproperty
  a_offset: assert property (p_offset)
    else $error("bad pin offset not reported");

  property p_timer_init;
    state_q == S_CHECK && ok && is_cio && ntmr_d != 2'h0
      |=> o_timer_init != 2'b00 ##1 o_timer_init == 2'b00;
  endproperty
  a_timer_init: assert property (p_timer_init)
    else $error("timers not reset to initial mode");

  property p_first_counter;
    cfg_q.tick_sel >= 3'h3 && cfg_q.tick_sel <= 3'h6 |=> !o_first_counter_en;
  endproperty
  a_first_counter: assert property (p_first_counter)
    else $error("first counter on with divided tick source");

  property p_uart;
    state_q == S_CHECK && !wm[WM_UART] |=> ##1 $stable(o_uart_pins);
  endproperty
  a_uart: assert property (p_uart)
    else $error("uart pins changed without mask bit");

  property p_dac_new;
    NEW_HW |-> o_dac2_en && !o_ain_ref_vreg;
  endproperty
  a_dac_new: assert property (p_dac_new)
    else $error("second dac not held on new revision");

  property p_ref;
    !NEW_HW && cfg_q.dac_ctl[0] |=> o_ain_ref_vreg;
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference not moved to regulator");

  property p_fio;
    state_q == S_CHECK && ok && wm[WM_FIO]
      |=> ##1 o_fio_analog == $past(rx_q[10], 2);
  endproperty
  a_fio: assert property (p_fio)
    else $error("flexible analog mask not applied");

  property p_tck_read;
    state_q == S_CHECK && is_tck && !rx_q[8][7]
      |=> $stable(cfg_q.tick_sel) && $stable(cfg_q.tick_div);
  endproperty
  a_tck_read: assert property (p_tck_read)
    else $error("tick config changed on read only");

  property p_hdr;
    o_tx.valid && tx_idx_q == 4'h2 |-> o_tx.data == HDR_SYNC;
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("response header byte wrong");
endmodule : icch_handler

// >>> icch_host.sv
// host model: sends command packets and collects the response bytes
// assumes tasks are entered on a falling edge of i_clk
`timescale 1ns/100ps
module icch_host (
  input wire logic i_clk,
  input wire logic i_rx_ready,
  input icch_pkg::icch_stream_type i_tx,
  output icch_pkg::icch_stream_type o_rx,
  output logic o_tx_ready
);
  import icch_pkg::*;
  int stall_pct = 0;
  logic [7:0] rsp_q[$];
  logic rsp_done = 1'b0;
  logic [7:0] last_b = 8'h00;

  initial begin
    o_rx = '0;
    o_tx_ready = 1'b1;
  end

  // ready drawn first, so a byte seen here is taken at the next rise
  always @(negedge i_clk) begin
    o_tx_ready = ($urandom_range(99) >= stall_pct);
    if (i_tx.valid && o_tx_ready) begin
      rsp_q.push_back(i_tx.data);
      if (i_tx.last) rsp_done = 1'b1;
    end
  end

  task automatic xfer(input icch_pkt_type p, input int len,
                      output icch_pkt_type r, output int rlen);
    int n;
    rsp_q.delete();
    rsp_done = 1'b0;
    for (int i = 0; i < len; i++) begin
      o_rx = '{valid: 1'b1, last: (i == len - 1), data: p[i]};
      n = 0;
      while (!i_rx_ready && n < 100) begin
        @(negedge i_clk);
        n++;
      end
      @(negedge i_clk);
      last_b = p[i];
    end
    // released data lines show the inverse of the last byte
    o_rx = '{valid: 1'b0, last: 1'b0, data: ~last_b};
    n = 0;
    while (!rsp_done && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    r = '0;
    rlen = rsp_q.size();
    for (int i = 0; i < rlen && i < MAX_LEN; i++) r[i] = rsp_q[i];
  endtask : xfer
endmodule : icch_host

// >>> icch_handler_tb.sv
// self-checking bench of the io configuration command handler
// assumes the package, design files and host model are compiled first
`timescale 1ns/100ps
module icch_handler_tb;
  import icch_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_base_tick = 1'b0;
  icch_stream_type rx, tx;
  logic rx_ready, tx_ready, c0_en, c1_en, dac2_en, ref_vreg, uart_pins;
  logic tick, dac2_old, vreg_old;
  icch_cfg_type cfg;
  icch_lines_type lines;
  logic [1:0] tmr_cnt, tmr_init;
  logic [7:0] fio_an, eio_an;
  int miscompares = 0;
  int checked = 0;
  int init_seen = 0;
  int init_exp = 0;
  int ticks = 0;
  logic [7:0] e_pin = RST_PIN_CFG, e_fio = RST_FIO, e_eio = RST_EIO;
  logic [7:0] e_div = RST_TDIV;
  logic [2:0] e_sel = RST_TSEL;
  logic e_uart = 1'b0, e_dac_old = 1'b0;

  icch_host host_u (.i_clk(i_clk), .i_rx_ready(rx_ready), .i_tx(tx),
    .o_rx(rx), .o_tx_ready(tx_ready));
  icch_handler dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rx(rx),
    .o_rx_ready(rx_ready), .o_tx(tx), .i_tx_ready(tx_ready),
    .i_base_tick(i_base_tick), .o_cfg(cfg), .o_lines(lines),
    .o_timer_count(tmr_cnt), .o_first_counter_en(c0_en), .o_second_counter_en(c1_en),
    .o_timer_init(tmr_init), .o_dac2_en(dac2_en), .o_ain_ref_vreg(ref_vreg),
    .o_uart_pins(uart_pins), .o_fio_analog(fio_an), .o_eio_analog(eio_an),
    .o_tick(tick));
  // older revision fed the same packets, watched for the dac and regulator reference only
  icch_handler #(.P_HW_REV(8'h81)) dut_old_u (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_rx(rx), .o_rx_ready(), .o_tx(),
    .i_tx_ready(tx_ready), .i_base_tick(i_base_tick), .o_cfg(), .o_lines(),
    .o_timer_count(), .o_first_counter_en(), .o_second_counter_en(), .o_timer_init(),
    .o_dac2_en(dac2_old), .o_ain_ref_vreg(vreg_old), .o_uart_pins(),
    .o_fio_analog(), .o_eio_analog(), .o_tick());

  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    init_seen += tmr_init[0] + tmr_init[1];
    ticks += tick;
  end

  task automatic check_val(input string what, input logic [47:0] exp,
                           input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic check_count(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      miscompares++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_count

  function automatic icch_pkt_type seal(input icch_pkt_type p, input int len);
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 6; i < len; i++) s += 16'(p[i]);
    p[4] = s[7:0];
    p[5] = s[15:8];
    s = 16'h0000;
    for (int i = 1; i < 6; i++) s += 16'(p[i]);
    s = 16'(s[15:8]) + 16'(s[7:0]);
    s = 16'(s[15:8]) + 16'(s[7:0]);
    p[0] = s[7:0];
    return p;
  endfunction : seal

  task automatic cfg_cmd(input logic [7:0] mask, pin, dac, fio, eio,
                         input int bad, input logic [7:0] err);
    icch_pkt_type p, r, q;
    int rlen;
    logic c0e;
    logic [4:0] off;
    p = '0;
    p[1] = HDR_SYNC;
    p[2] = CIO_WORDS;
    p[3] = (bad == 3) ? 8'h0C : CIO_CMD;
    p[6] = mask;
    p[8] = pin;
    p[9] = dac;
    p[10] = fio;
    p[11] = eio;
    p = seal(p, 12);
    if (bad == 1) p[0] = ~p[0];
    if (bad == 2) p[10] = p[10] + 8'h01;
    host_u.xfer(p, 12, r, rlen);
    q = seal(r, 12);
    if (err === ERR_NONE) begin
      if (mask[WM_PIN]) e_pin = pin;
      if (mask[WM_DAC]) e_dac_old = dac[DC_EN];
      if (mask[WM_FIO]) e_fio = fio;
      if (mask[WM_EIO]) e_eio = eio;
      if (mask[WM_UART]) e_uart = dac[DC_UART];
      init_exp += e_pin[1:0];
    end
    check_count("response length", 12, rlen);
    check_val("header", {CIO_CMD, CIO_WORDS, HDR_SYNC}, r[3:1]);
    check_val("sums", {q[5], q[4], q[0]}, {r[5], r[4], r[0]});
    check_val("error result", err, r[6]);
    check_val("pin config", e_pin, r[8]);
    check_val("dac byte", {e_uart, 2'h1}, r[9] & 8'h05);
    check_val("analog bytes", {e_fio, e_eio}, {r[10], r[11]});
    repeat (3) @(negedge i_clk);
    c0e = e_pin[PC_C0] && !(e_sel >= SEL_DIV_MIN && e_sel <= SEL_DIV_MAX);
    off = 5'(e_pin[7:4]);
    check_val("counters", {c0e, e_pin[PC_C1]}, {c0_en, c1_en});
    check_val("timer count", e_pin[1:0], tmr_cnt);
    check_val("analog lines", {e_fio, e_eio}, {fio_an, eio_an});
    check_val("uart pins", e_uart, uart_pins);
    check_val("dac and ref", 2'h2, {dac2_en, ref_vreg});
    check_val("old dac", {2{e_dac_old}}, {dac2_old, vreg_old});
    if (e_pin[1:0] != 2'h0) check_val("t0 line", off, lines.t0);
    if (e_pin[1:0] == 2'h2) check_val("t1 line", off + 5'h1, lines.t1);
    if (c0e) check_val("c0 line", off + 5'(e_pin[1:0]), lines.c0);
    if (e_pin[PC_C1])
      check_val("c1 line", off + 5'(e_pin[1:0]) + 5'(c0e), lines.c1);
    check_count("mode 10 pulses", init_exp, init_seen);
  endtask : cfg_cmd

  task automatic clk_cmd(input logic [7:0] tcfg, div);
    icch_pkt_type p, r;
    int rlen;
    p = '0;
    p[1] = HDR_SYNC;
    p[2] = TCK_WORDS;
    p[3] = TCK_CMD;
    p[8] = tcfg;
    p[9] = div;
    p = seal(p, 10);
    host_u.xfer(p, 10, r, rlen);
    if (tcfg[TCFG_WR]) begin
      e_sel = tcfg[2:0];
      e_div = div;
    end
    check_count("clock length", 10, rlen);
    check_val("clock header", {TCK_CMD, TCK_WORDS}, r[3:2]);
    check_val("clock error", ERR_NONE, r[6]);
    check_val("tick reply", {e_sel, e_div}, {r[8][2:0], r[9]});
    repeat (3) @(negedge i_clk);
    check_val("tick stored", {e_sel, e_div}, cfg[10:0]);
  endtask : clk_cmd

  task automatic tick_run(input int n, input int exp);
    ticks = 0;
    repeat (n) begin
      i_base_tick = 1'b1;
      @(negedge i_clk);
    end
    i_base_tick = 1'b0;
    repeat (3) @(negedge i_clk);
    check_count("ticks", exp, ticks);
  endtask : tick_run

  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #(4 * 40000);
    miscompares++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    int seed;
    logic [7:0] mask, pin, dac;
    seed = $urandom(32'h0000_cbf9);
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    check_val("reset config", 48'({RST_PIN_CFG, RST_DAC, RST_FIO, RST_EIO,
      RST_TSEL, RST_TDIV}), 48'(cfg));
    check_val("reset flags", 3'h6, {rx_ready, dac2_en, dac2_old});
    $display("test reset done");
    cfg_cmd(8'h0D, 8'h61, 8'h00, 8'h30, 8'h03, 0, ERR_NONE);
    cfg_cmd(8'h00, 8'h12, 8'h05, 8'hFF, 8'hFF, 0, ERR_NONE);
    cfg_cmd(8'h01, 8'h4E, 8'h00, 8'h00, 8'h00, 0, ERR_NONE);
    cfg_cmd(8'h01, 8'h8E, 8'h00, 8'h00, 8'h00, 0, ERR_NONE);
    cfg_cmd(8'h01, 8'h3E, 8'h00, 8'h00, 8'h00, 0, ERR_PIN_OFFSET);
    cfg_cmd(8'h01, 8'h9E, 8'h00, 8'h00, 8'h00, 0, ERR_PIN_OFFSET);
    for (int b = 1; b < 4; b++)
      cfg_cmd(8'h2F, 8'h51, 8'h05, 8'hA5, 8'h5A, b, 8'(b));
    $display("test fixed commands done");
    host_u.stall_pct = 30;
    for (int k = 0; k < 40; k++) begin
      mask = 8'($urandom) & 8'h2F;
      pin = {4'($urandom_range(8, 4)), 2'($urandom), 2'($urandom_range(2))};
      dac = 8'($urandom) & 8'hFD;
      cfg_cmd(mask, pin, dac, 8'($urandom), 8'($urandom), 0, ERR_NONE);
    end
    $display("test random commands done");
    host_u.stall_pct = 0;
    cfg_cmd(8'h01, 8'h5C, 8'h00, 8'h00, 8'h00, 0, ERR_NONE);
    for (int s = 0; s < 7; s++) begin
      clk_cmd(8'h80 | 8'(s), 8'h02);
      cfg_cmd(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 0, ERR_NONE);
    end
    clk_cmd(8'h84, 8'h03);
    clk_cmd(8'h01, 8'hAA);
    tick_run(30, 10);
    clk_cmd(8'h84, 8'h00);
    tick_run(512, 2);
    clk_cmd(8'h81, 8'h05);
    tick_run(20, 20);
    $display("test timer clock done");
    tally_and_finish();
  end
endmodule : icch_handler_tb
